//--- rtl/fir_taps_mid_pkg.sv
// Purpose: Shared constants and types for the mid-tap coefficient bank.
// Assumes: Byte-addressed register port with 12-bit addresses and 24-bit data.
// Notes:   Offsets that are not word aligned are kept as printed.
package fir_taps_mid_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 24;
  localparam int COEF_W = 12;
  localparam int CTAP_W = 18;
  localparam int WIN_W  = 9;

  // Supported sample widths for the mid-tap datapath.
  localparam int MIN_SAMPLE_W = 2;
  localparam int MAX_SAMPLE_W = 16;

  // Window position of the sample that meets tap four, and the number of mid taps.
  localparam int FIRST_MID_SAMPLE = 3;
  localparam int MID_TAPS         = 4;

  // Slots of the mid taps in tap order.
  localparam int TAP4_SLOT   = 0;
  localparam int CENTER_SLOT = 1;
  localparam int TAP6_SLOT   = 2;
  localparam int TAP7_SLOT   = 3;

  // Register offsets.
  localparam logic [11:0] TAP4_OFS   = 12'h41E;
  localparam logic [11:0] CENTER_OFS = 12'h420;
  localparam logic [11:0] TAP6_OFS   = 12'h423;
  localparam logic [11:0] TAP7_OFS   = 12'h425;
  localparam logic [11:0] MODE_OFS   = 12'h410;

  // Register widths, including reserved bits.
  localparam int NARROW_REG_W = 16;
  localparam int CENTER_REG_W = 24;
  localparam int MODE_W       = 2;

  localparam logic [23:0] REG_RESET = 24'h000000;

  // Filter mode field encodings.
  localparam logic [1:0] MODE_BYPASS = 2'h0;
  localparam logic [1:0] MODE_ENABLE = 2'h2;

  // Coefficient set handed to the filter datapath.
  typedef struct packed {
    logic signed [11:0] tap4;
    logic signed [17:0] center;
    logic signed [11:0] tap6;
    logic signed [11:0] tap7;
  } mid_coefs_t;

  // Register port request.
  typedef struct packed {
    logic [11:0] addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

//--- rtl/fir_taps_mid.sv
// Purpose: Holds the fourth to seventh filter coefficients and applies them to a sample window.
// Assumes: Software only rewrites coefficients while the serial link is disabled.
//          Register port strobes are one cycle long and never wait.
// Notes:   Readback of each coefficient field shows its top bit as zero.
//          The filter itself always sees the full stored value, sign bit included.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

// Functional notes
// - Tap four: 12-bit signed at 0x41E.
// - Centre tap: 18-bit signed at 0x420.
// - Tap six: 12-bit signed at 0x423.
// - Tap seven: 12-bit signed at 0x425.
// - Same registers serve single-channel filter.
// - Readback forces coefficient MSB to zero.
// - All registers reset to zero.
// - Mode 0 bypasses, 2 enables filter.
module fir_taps_mid
  import fir_taps_mid_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                         clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic [ADDR_W-1:0]            addr_in,
  input  wire logic [DATA_W-1:0]            wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  input  wire logic                         single_channel_in,
  input  wire logic [SAMPLE_W*WIN_W-1:0]    window_in,
  output logic [DATA_W-1:0]                 rdata_out,
  output mid_coefs_t                        coefs_out,
  output logic signed [SAMPLE_W+CTAP_W+1:0] partial_sum_out,
  output logic                              filter_active_out
);

  // Refuses sample widths that the product and sum widths below are not sized for.
  // A sample narrower than the lower limit has no magnitude beside its sign, and one
  // wider than the upper limit is beyond what the downstream adder tree was sized for.
  if (SAMPLE_W < MIN_SAMPLE_W || SAMPLE_W > MAX_SAMPLE_W) begin : g_bad_sample_w
    $error("SAMPLE_W out of supported range");
  end

  // Refuses a tap placement that would reach past the end of the sample window.
  if (FIRST_MID_SAMPLE + MID_TAPS > WIN_W) begin : g_bad_window
    $error("Mid taps do not fit the sample window");
  end

  // Gathers the register port into one request carrier.
  reg_req_t req;
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Stored registers hold every written bit, reserved bits included, so that
  // software reads back in those bits exactly what it wrote there.
  logic [NARROW_REG_W-1:0] fir_tap4_coef_chan_a;
  logic [CENTER_REG_W-1:0] fir_center_tap_coef_chan_a;
  logic [NARROW_REG_W-1:0] fir_tap6_coef_chan_a;
  logic [NARROW_REG_W-1:0] fir_tap7_coef_chan_a;
  logic [MODE_W-1:0]       fir_enable_select;

  // Decodes the address for each register; a miss on all of them reads zero.
  wire hit_tap4   = req.addr == TAP4_OFS;
  wire hit_center = req.addr == CENTER_OFS;
  wire hit_tap6   = req.addr == TAP6_OFS;
  wire hit_tap7   = req.addr == TAP7_OFS;
  wire hit_mode   = req.addr == MODE_OFS;
  wire hit_any    = hit_tap4 | hit_center | hit_tap6 | hit_tap7 | hit_mode;

  // Qualifies each decode with the write strobe, so unmapped writes change nothing.
  wire wr_tap4   = req.wr & hit_tap4;
  wire wr_center = req.wr & hit_center;
  wire wr_tap6   = req.wr & hit_tap6;
  wire wr_tap7   = req.wr & hit_tap7;
  wire wr_mode   = req.wr & hit_mode;

  // Clears one sign bit of a stored word for readback; the stored value keeps it,
  // so the filter still sees negative coefficients while software reads a zero there.
  function automatic logic [DATA_W-1:0] hide_sign(input logic [DATA_W-1:0] value, input int sign_bit);
    hide_sign = value & ~(DATA_W'(1'h1) << sign_bit);
  endfunction

  // Forms the readback value of each register, the top bit of every coefficient hidden.
  wire [DATA_W-1:0] rd_tap4   = hide_sign(DATA_W'(fir_tap4_coef_chan_a), COEF_W - 1);
  wire [DATA_W-1:0] rd_center = hide_sign(fir_center_tap_coef_chan_a, CTAP_W - 1);
  wire [DATA_W-1:0] rd_tap6   = hide_sign(DATA_W'(fir_tap6_coef_chan_a), COEF_W - 1);
  wire [DATA_W-1:0] rd_tap7   = hide_sign(DATA_W'(fir_tap7_coef_chan_a), COEF_W - 1);
  wire [DATA_W-1:0] rd_mode   = DATA_W'(fir_enable_select);

  // Selects the readback word; unmapped addresses read zero.
  logic [DATA_W-1:0] next_rdata;
  assign next_rdata = !hit_any   ? REG_RESET :
                      hit_tap4   ? rd_tap4 :
                      hit_center ? rd_center :
                      hit_tap6   ? rd_tap6 :
                      hit_tap7   ? rd_tap7 :
                      rd_mode;

  // Holds the tap four register, written whole including its reserved bits.
  // A write is taken at the edge that sees the strobe and never stalls.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fir_tap4_coef_chan_a <= NARROW_REG_W'(REG_RESET);
    end else if (wr_tap4) begin
      fir_tap4_coef_chan_a <= req.wdata[NARROW_REG_W-1:0];
    end
  end

  // Holds the centre tap register, written whole including its reserved bits.
  // Its field is wider than the others because it carries most of the filter gain.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fir_center_tap_coef_chan_a <= REG_RESET;
    end else if (wr_center) begin
      fir_center_tap_coef_chan_a <= req.wdata;
    end
  end

  // Holds the tap six register, written whole including its reserved bits.
  // Only the lower 16 bits of the write data reach this narrow register.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fir_tap6_coef_chan_a <= NARROW_REG_W'(REG_RESET);
    end else if (wr_tap6) begin
      fir_tap6_coef_chan_a <= req.wdata[NARROW_REG_W-1:0];
    end
  end

  // Holds the tap seven register, written whole including its reserved bits.
  // Only the lower 16 bits of the write data reach this narrow register.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fir_tap7_coef_chan_a <= NARROW_REG_W'(REG_RESET);
    end else if (wr_tap7) begin
      fir_tap7_coef_chan_a <= req.wdata[NARROW_REG_W-1:0];
    end
  end

  // Holds the filter mode field; the reserved codes are stored but act as bypass.
  // Reset leaves the filter bypassed until software has loaded its coefficients.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fir_enable_select <= MODE_BYPASS;
    end else if (wr_mode) begin
      fir_enable_select <= req.wdata[MODE_W-1:0];
    end
  end

  // Returns read data in the cycle after the read strobe and zero in every other cycle.
  // Driving zero outside reads keeps stale words off a shared read bus.
  // The port never inserts wait states.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= REG_RESET;
    end else begin
      rdata_out <= req.rd ? next_rdata : REG_RESET;
    end
  end

  // Presents the coefficients to the filter; channel A or the sole filter alike.
  mid_coefs_t next_coefs;
  assign next_coefs.tap4   = fir_tap4_coef_chan_a[COEF_W-1:0];
  assign next_coefs.center = fir_center_tap_coef_chan_a[CTAP_W-1:0];
  assign next_coefs.tap6   = fir_tap6_coef_chan_a[COEF_W-1:0];
  assign next_coefs.tap7   = fir_tap7_coef_chan_a[COEF_W-1:0];

  // Lists the coefficients in tap order, sign-extended to the centre tap's width,
  // so that one loop below serves all four taps alike.
  logic signed [CTAP_W-1:0] tap_coef [MID_TAPS];
  assign tap_coef[TAP4_SLOT]   = CTAP_W'($signed(next_coefs.tap4));
  assign tap_coef[CENTER_SLOT] = next_coefs.center;
  assign tap_coef[TAP6_SLOT]   = CTAP_W'($signed(next_coefs.tap6));
  assign tap_coef[TAP7_SLOT]   = CTAP_W'($signed(next_coefs.tap7));

  // Sizes products and sums so that four full-scale products cannot overflow.
  // The chain starts from zero and adds one tap product per stage.
  localparam int PW = SAMPLE_W + CTAP_W + 2;
  logic signed [PW-1:0] tap_product [MID_TAPS];
  logic signed [PW-1:0] running_sum [MID_TAPS+1];
  assign running_sum[0] = '0;

  // Multiplies each mid tap with its window sample; the centre tap meets the middle
  // sample of the window, and both operands are widened before the product is formed.
  for (genvar k = 0; k < MID_TAPS; k++) begin : g_tap
    wire signed [SAMPLE_W-1:0] sample = window_in[(FIRST_MID_SAMPLE + k) * SAMPLE_W +: SAMPLE_W];
    assign tap_product[k]   = PW'(sample) * PW'(tap_coef[k]);
    assign running_sum[k+1] = running_sum[k] + tap_product[k];
  end

  // Decodes the mode field; only the enable code lets the sum through.
  // The reserved codes fall back to bypass rather than to an undefined datapath.
  wire filter_on = fir_enable_select == MODE_ENABLE;
  wire signed [PW-1:0] next_partial = filter_on ? running_sum[MID_TAPS] : '0;

  // Registers the coefficients handed to the filter datapath.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      coefs_out <= '0;
    end else begin
      coefs_out <= next_coefs;
    end
  end

  // Registers the partial sum of the mid taps; it is zero while the filter is bypassed.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      partial_sum_out <= '0;
    end else begin
      partial_sum_out <= next_partial;
    end
  end

  // Registers the enable indication beside the sum, so both change on the same edge.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      filter_active_out <= 1'h0;
    end else begin
      filter_active_out <= filter_on;
    end
  end

  // Channel mode only selects which filter consumes coefs_out; storage is shared.
  wire unused_single = single_channel_in;

endmodule

//--- dv/fir_taps_mid_properties.sv
// Purpose: Port-level checks of the mid-tap coefficient bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ps
module fir_taps_mid_properties
  import fir_taps_mid_pkg::*;
#(parameter int SAMPLE_W = 12) (
  input wire logic                            clk_in, arst_n_in, wr_in, rd_in, single_channel_in, filter_active_out,
  input wire logic [ADDR_W-1:0]               addr_in,
  input wire logic [DATA_W-1:0]               wdata_in, rdata_out,
  input wire logic [SAMPLE_W*WIN_W-1:0]       window_in,
  input wire mid_coefs_t                      coefs_out,
  input wire logic signed [SAMPLE_W+CTAP_W+1:0] partial_sum_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // A write reaches the stored register at its edge and coefs_out one edge later,
  // so it shows two edges on, unless the next cycle rewrites the same register.
  a_tap4_write: assert property (wr_in && addr_in == TAP4_OFS ##1 !(wr_in && addr_in == TAP4_OFS)
    |=> coefs_out.tap4 == $past(wdata_in[11:0], 2))
    else $error("tap4 write lost");
  a_center_write: assert property (wr_in && addr_in == CENTER_OFS ##1 !(wr_in && addr_in == CENTER_OFS)
    |=> coefs_out.center == $past(wdata_in[17:0], 2))
    else $error("center write lost");
  a_tap6_write: assert property (wr_in && addr_in == TAP6_OFS ##1 !(wr_in && addr_in == TAP6_OFS)
    |=> coefs_out.tap6 == $past(wdata_in[11:0], 2))
    else $error("tap6 write lost");
  a_tap7_write: assert property (wr_in && addr_in == TAP7_OFS ##1 !(wr_in && addr_in == TAP7_OFS)
    |=> coefs_out.tap7 == $past(wdata_in[11:0], 2))
    else $error("tap7 write lost");
  // Readback hides the top bit of each field.
  a_narrow_read: assert property (rd_in && addr_in == TAP7_OFS
    |=> rdata_out[11:0] == {1'h0, coefs_out.tap7[10:0]})
    else $error("tap7 readback wrong");
  a_center_read: assert property (rd_in && addr_in == CENTER_OFS
    |=> rdata_out[17:0] == {1'h0, coefs_out.center[16:0]})
    else $error("center readback wrong");
  // Read data stands only in the cycle after a read strobe.
  a_rdata_idle: assert property (!rd_in |=> rdata_out == '0)
    else $error("read data outside a read");
  a_reset_clear: assert property ($rose(arst_n_in) |-> coefs_out == '0 && !filter_active_out)
    else $error("outputs not clear after reset");
  a_bypass_zero: assert property (!filter_active_out && $past(!filter_active_out) |-> partial_sum_out == 0)
    else $error("sum while bypassed");
  cover property (wr_in && addr_in == CENTER_OFS);
  cover property (filter_active_out);
  cover property (rd_in && addr_in == TAP7_OFS);
endmodule
bind fir_taps_mid fir_taps_mid_properties #(.SAMPLE_W(SAMPLE_W)) chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .wr_in(wr_in), .rd_in(rd_in), .single_channel_in(single_channel_in), .filter_active_out(filter_active_out),
  .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .window_in(window_in), .coefs_out(coefs_out),
  .partial_sum_out(partial_sum_out));

//--- dv/test_fir_taps_mid.sv
// Purpose: Self-checking bench for the mid-tap coefficient bank.
// Assumes: Strobes driven just after rising edges, read data one cycle later.
// Notes:   Twelve-bit samples.
`timescale 1ns/1ps
module test_fir_taps_mid import fir_taps_mid_pkg::*;;
  logic        clk_in = 0, arst_n_in = 0, wr_in = 0, rd_in = 0, single_channel_in = 0, filter_active_out;
  logic [11:0] addr_in = '0;
  logic [23:0] wdata_in = '0, rdata_out;
  logic [107:0] window_in = '0;
  mid_coefs_t  coefs_out;
  logic signed [31:0] partial_sum_out;
  int          mismatches = 0, tests_run = 0;
  logic [11:0] regs [4] = '{TAP4_OFS, CENTER_OFS, TAP6_OFS, TAP7_OFS};
  fir_taps_mid #(.SAMPLE_W(12)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .single_channel_in(single_channel_in), .window_in(window_in),
    .rdata_out(rdata_out), .coefs_out(coefs_out), .partial_sum_out(partial_sum_out), .filter_active_out(filter_active_out));
  // Free-running 40 MHz clock.
  initial forever #12.5 clk_in = ~clk_in;
  task automatic check(input string what, input logic [63:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic write(input logic [11:0] a, input logic [23:0] d);
    @(posedge clk_in);
    wr_in <= 1'h1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask
  task automatic read(input logic [11:0] a, input logic [23:0] exp);
    @(posedge clk_in);
    rd_in <= 1'h1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 check("rdata", exp, rdata_out);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Every coefficient register and an unmapped address read zero after reset.
  task automatic reset_values();
    foreach (regs[i]) read(regs[i], 24'h000000);
    read(12'h41F, 24'h000000);
  endtask
  // All-ones written in both channel modes; top field bit reads back zero.
  task automatic store_and_readback();
    for (int i = 0; i < 4; i++) begin
      single_channel_in <= i[0];
      write(regs[i], 24'hFFFFFF);
      read(regs[i], i == 1 ? 24'hFDFFFF : 24'h00F7FF);
    end
    write(12'h41F, 24'h000000);
    #1 check("coefs", {12'hFFF, 18'h3FFFF, 12'hFFF, 12'hFFF}, coefs_out);
  endtask
  // Distinct taps and samples expose tap order; every mode code is tried.
  task automatic filter_math();
    write(TAP4_OFS, 24'h000001);
    write(CENTER_OFS, 24'h000002);
    write(TAP6_OFS, 24'h000003);
    write(TAP7_OFS, 24'h000004);
    window_in <= {12'h005, 12'h005, 12'hFFF, 12'h003, 12'h002, 12'h001, 12'h005, 12'h005, 12'h005};
    for (int m = 0; m < 4; m++) begin
      write(MODE_OFS, 24'(m));
      repeat (2) @(posedge clk_in);
      #1 check("sum", m == 2 ? 64'hA : 64'h0, partial_sum_out);
      check("active", 64'(m == 2), filter_active_out);
    end
  endtask
  // A reset in mid-run clears the coefficients, the mode and the outputs again.
  task automatic reset_again();
    @(posedge clk_in);
    arst_n_in <= 1'h0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'h1;
    #1 check("coefs", 64'h0, coefs_out);
    check("sum", 64'h0, partial_sum_out);
    check("active", 64'h0, filter_active_out);
    foreach (regs[i]) read(regs[i], 24'h000000);
    read(MODE_OFS, 24'h000000);
  endtask
  // Main sequence, run with the serial link held off so every rewrite is legal.
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'h1;
    reset_values();
    store_and_readback();
    filter_math();
    reset_again();
    test_done();
  end
  // Watchdog against a hung sequence; the scenarios need about 2 us.
  initial begin
    #10us;
    mismatches++;
    test_done();
  end
endmodule
